// *** lpdci_top.sv ***
// Purpose: Command and control input stage of a low-power DDR memory device
// Assumes: CLK marks the true-rise / complement-fall crossing; inputs synchronous
// Notes: A small flip-flop array stands for the storage so writes can be masked
//
// What this block does
// [R1] Address and control inputs are registered only at the rising crossing of the clock pair.
// [R2] Data moves on both crossings, so each clock period carries a rise beat and a fall beat.
// [R3] Clock-gate high runs internal clocks, input buffers and drivers; low stops them.
// [R4] Clock-gate low with all banks idle gives precharge power-down or self refresh, else active power-down.
// [R5] Clock-gate is synchronous except self-refresh exit, which is seen without a running clock; INT_CLK_RUN follows CKE on power-down exit as well.
// [R6] In power-down or self refresh every input but the clock-gate is ignored.
// [R7] Commands are decoded only when die-select is registered low and ignored when high.
// [R8] The command comes from row strobe, column strobe and write enable together with die-select.
// [R9] A write beat whose byte mask is high is dropped and that stored byte stays unchanged.
// [R10] Byte masks are captured on both strobe edges, like the write data.
// [R11] Activate, read, write and single-bank precharge use the two bank-select inputs to pick a bank.
// [R12] Load-mode-register uses the bank-select inputs to pick which mode register takes the address.
// [R13] Precharge with address bit ten low closes one bank, high closes all; on read or write it asks auto precharge.
// [R14] The device drives the strobe edge-aligned with read data; the controller drives it centred with write data.
// [R15] Each byte lane has its own mask and strobe: lower lane bits 7 to 0, upper lane bits 15 to 8.
// [R16] The controller encodes commands with the usual low-power DDR command code table.
// [R17] The controller holds clock-gate low for the whole low-power interval and raises it only to exit.

`timescale 1ns/1ps

module lpdci_top
    import lpdci_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Command and address
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [BA_W-1:0] BA,
    input wire logic [ADDR_W-1:0] ADDR,
    // Write data beats, strobes and masks; bit 0 rise, bit 1 fall
    input wire logic [DQ_W-1:0] DQ_RISE_IN,
    input wire logic [DQ_W-1:0] DQ_FALL_IN,
    input wire logic [BEATS-1:0] LOWER_DATA_STROBE_IN,
    input wire logic [BEATS-1:0] UPPER_DATA_STROBE_IN,
    input wire logic [BEATS-1:0] LOWER_BYTE_MASK,
    input wire logic [BEATS-1:0] UPPER_BYTE_MASK,
    // Read data beats and strobes
    output logic [DQ_W-1:0] DQ_RISE_OUT,
    output logic [DQ_W-1:0] DQ_FALL_OUT,
    output logic DQ_OE_N,
    output logic [BEATS-1:0] LOWER_DATA_STROBE_OUT,
    output logic [BEATS-1:0] UPPER_DATA_STROBE_OUT,
    output logic DATA_STROBE_OE_N,
    // Power and status
    output logic INT_CLK_RUN,
    output logic INPUT_BUF_EN,
    output logic PD_PRECHARGE,
    output logic PD_ACTIVE,
    output logic SELF_REFRESH,
    output logic [NUM_BANKS-1:0] BANK_OPEN,
    output logic [ADDR_W-1:0] MODE_REG,
    output logic [ADDR_W-1:0] EXT_MODE_REG
);

    // ************************************************************
    // Command decode
    // ************************************************************
    function automatic lpdci_cmd_t decode_cmd(input logic cs_n, input logic [2:0] code);
        lpdci_cmd_t c;
        c = LPDCI_NOP;
        if (!cs_n)
        begin
            case (code)
                CODE_LMR: c = LPDCI_LMR;
                CODE_REF: c = LPDCI_REF;
                CODE_PRE: c = LPDCI_PRE;
                CODE_ACT: c = LPDCI_ACT;
                CODE_WR: c = LPDCI_WR;
                CODE_RD: c = LPDCI_RD;
                CODE_BST: c = LPDCI_BST;
                default: c = LPDCI_NOP;
            endcase
        end
        return c;
    endfunction

    lpdci_pwr_t pwr_ff;
    lpdci_pwr_t nxt_pwr;
    lpdci_cmd_t cmd;
    logic run;
    logic cmd_ok;
    logic [NUM_BANKS-1:0] bank_open_ff;
    logic [NUM_BANKS-1:0] nxt_bank_open;
    logic wr_pend_ff;
    logic [HALF_IDX_W-1:0] wr_idx_ff;
    logic ap_pend_ff;
    logic [BA_W-1:0] ap_bank_ff;
    logic [HALF_IDX_W-1:0] cmd_idx;
    logic is_rd;
    logic [BEATS-1:0] lane_strobe_w [LANES];
    logic [BEATS-1:0] lane_mask_w [LANES];
    logic [BYTE_W-1:0] beat_out_w [BEATS][LANES];

    assign cmd = decode_cmd(CS_N, {RAS_N, CAS_N, WE_N}); // [R8]
    assign run = (pwr_ff == LPDCI_RUN);
    assign cmd_ok = run && CKE && (cmd != LPDCI_NOP); // [R1] [R6] [R7]
    assign cmd_idx = {BA, ADDR[COL_PAIR_BIT]}; // [R11]
    assign is_rd = cmd_ok && (cmd == LPDCI_RD);

    // ************************************************************
    // Power state
    // ************************************************************
    always_comb
    begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            LPDCI_RUN:
            begin
                if (!CKE) // [R4]
                begin
                    if (cmd == LPDCI_REF && bank_open_ff == '0)
                        nxt_pwr = LPDCI_SELF_REF;
                    else if (bank_open_ff != '0)
                        nxt_pwr = LPDCI_ACT_PD;
                    else
                        nxt_pwr = LPDCI_PRE_PD;
                end
            end
            LPDCI_PRE_PD, LPDCI_ACT_PD, LPDCI_SELF_REF:
            begin
                if (CKE) // [R17]
                    nxt_pwr = LPDCI_RUN;
            end
            default: nxt_pwr = LPDCI_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            pwr_ff <= LPDCI_RUN;
        else
            pwr_ff <= nxt_pwr;
    end

    assign INT_CLK_RUN = run || CKE; // [R3] [R5]
    assign INPUT_BUF_EN = run; // [R6]
    assign PD_PRECHARGE = (pwr_ff == LPDCI_PRE_PD);
    assign PD_ACTIVE = (pwr_ff == LPDCI_ACT_PD);
    assign SELF_REFRESH = (pwr_ff == LPDCI_SELF_REF);

    // ************************************************************
    // Bank state
    // ************************************************************
    always_comb
    begin
        nxt_bank_open = bank_open_ff;
        if (ap_pend_ff)
            nxt_bank_open[ap_bank_ff] = 1'b0; // [R13]
        if (cmd_ok)
        begin
            case (cmd)
                LPDCI_ACT: nxt_bank_open[BA] = 1'b1; // [R11]
                LPDCI_PRE:
                begin
                    if (ADDR[AP_BIT]) // [R13]
                        nxt_bank_open = '0;
                    else
                        nxt_bank_open[BA] = 1'b0;
                end
                default: nxt_bank_open = nxt_bank_open;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            bank_open_ff <= '0;
        else
            bank_open_ff <= nxt_bank_open;
    end

    assign BANK_OPEN = bank_open_ff;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ap_pend_ff <= 1'b0;
            ap_bank_ff <= '0;
        end
        else
        begin
            ap_pend_ff <= cmd_ok && (cmd == LPDCI_RD || cmd == LPDCI_WR) && ADDR[AP_BIT]; // [R13]
            ap_bank_ff <= BA;
        end
    end

    // ************************************************************
    // Mode registers
    // ************************************************************
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            MODE_REG <= MODE_REG_RST;
            EXT_MODE_REG <= EXT_MODE_REG_RST;
        end
        else if (cmd_ok && cmd == LPDCI_LMR)
        begin
            if (BA == MR_SEL_STD) // [R12]
                MODE_REG <= ADDR;
            if (BA == MR_SEL_EXT) // [R12]
                EXT_MODE_REG <= ADDR;
        end
    end

    // ************************************************************
    // Write capture control
    // ************************************************************
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= '0;
        end
        else
        begin
            wr_pend_ff <= cmd_ok && (cmd == LPDCI_WR);
            wr_idx_ff <= cmd_idx; // [R11]
        end
    end

    // ************************************************************
    // Read strobe and output enables
    // ************************************************************
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            DQ_OE_N <= 1'b1;
            DATA_STROBE_OE_N <= 1'b1;
            LOWER_DATA_STROBE_OUT <= STROBE_IDLE;
            UPPER_DATA_STROBE_OUT <= STROBE_IDLE;
        end
        else
        begin
            DQ_OE_N <= !is_rd;
            DATA_STROBE_OE_N <= !is_rd; // [R14]
            LOWER_DATA_STROBE_OUT <= is_rd ? STROBE_READ : STROBE_IDLE; // [R14]
            UPPER_DATA_STROBE_OUT <= is_rd ? STROBE_READ : STROBE_IDLE; // [R14]
        end
    end

    // ************************************************************
    // Byte lanes and beats
    // ************************************************************
    assign lane_strobe_w[0] = LOWER_DATA_STROBE_IN; // [R15]
    assign lane_strobe_w[1] = UPPER_DATA_STROBE_IN; // [R15]
    assign lane_mask_w[0] = LOWER_BYTE_MASK; // [R15]
    assign lane_mask_w[1] = UPPER_BYTE_MASK; // [R15]

    genvar gl;
    genvar gb;
    generate
        for (gl = 0; gl < LANES; gl++)
        begin : g_lane
            for (gb = 0; gb < BEATS; gb++)
            begin : g_beat
                logic [BYTE_W-1:0] bytes_ff [HALF_DEPTH];
                logic [BYTE_W-1:0] rd_byte_ff;
                logic [BYTE_W-1:0] wdata;
                logic wr_en;

                assign wdata = (gb == 0) ? DQ_RISE_IN[gl*BYTE_W +: BYTE_W]
                                         : DQ_FALL_IN[gl*BYTE_W +: BYTE_W]; // [R2]
                assign wr_en = wr_pend_ff && run && lane_strobe_w[gl][gb]
                               && !lane_mask_w[gl][gb]; // [R9] [R10]

                always_ff @(posedge CLK or negedge NRST)
                begin
                    if (!NRST)
                    begin
                        for (int i = 0; i < HALF_DEPTH; i++)
                            bytes_ff[i] <= '0;
                    end
                    else if (wr_en)
                        bytes_ff[wr_idx_ff] <= wdata; // [R9]
                end

                always_ff @(posedge CLK or negedge NRST)
                begin
                    if (!NRST)
                        rd_byte_ff <= '0;
                    else if (is_rd)
                        rd_byte_ff <= bytes_ff[cmd_idx]; // [R2] [R11]
                end

                assign beat_out_w[gb][gl] = rd_byte_ff;

                AST_MASK_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
                    wr_pend_ff && lane_mask_w[gl][gb] |=>
                    bytes_ff[$past(wr_idx_ff)] == $past(bytes_ff[wr_idx_ff])) // [R9]
                    else $error("Masked beat changed stored byte");
            end
        end
    endgenerate

    assign DQ_RISE_OUT = {beat_out_w[0][1], beat_out_w[0][0]};
    assign DQ_FALL_OUT = {beat_out_w[1][1], beat_out_w[1][0]};

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    AST_CS_HIGH_IGNORED: assert property (CS_N |=> $stable(MODE_REG) && // [R7]
        (BANK_OPEN & ~$past(BANK_OPEN)) == '0 && DQ_OE_N)
        else $error("Command taken with die-select high");

    AST_ACT_OPENS: assert property (run && CKE && !CS_N && {RAS_N, CAS_N, WE_N} == CODE_ACT
        |=> BANK_OPEN[$past(BA)]) // [R11]
        else $error("Activate did not open the selected bank");

    AST_PRE_ALL: assert property (run && CKE && cmd == LPDCI_PRE && ADDR[AP_BIT]
        |=> BANK_OPEN == '0) // [R13]
        else $error("Precharge all left a bank open");

    AST_AUTO_PRE: assert property (run && CKE && cmd == LPDCI_RD && ADDR[AP_BIT] ##1 !(run
        && CKE && cmd == LPDCI_ACT) |=> !BANK_OPEN[$past(BA, 2)]) // [R13]
        else $error("Auto precharge did not close the bank");

    AST_LMR_STD: assert property (run && CKE && cmd == LPDCI_LMR && BA == MR_SEL_STD
        |=> MODE_REG == $past(ADDR) && $stable(EXT_MODE_REG)) // [R12]
        else $error("Mode register load went to the wrong register");

    AST_PD_ENTRY: assert property (run && !CKE && BANK_OPEN == '0 && cmd != LPDCI_REF
        |=> PD_PRECHARGE && !INPUT_BUF_EN) // [R4]
        else $error("Precharge power-down not entered");

    AST_APD_ENTRY: assert property (run && !CKE && BANK_OPEN != '0 && !ap_pend_ff
        |=> PD_ACTIVE ##0 $stable(BANK_OPEN)) // [R4]
        else $error("Active power-down not entered");

    AST_LOW_POWER_DEAF: assert property (!run && !CKE |=> $stable(BANK_OPEN) && // [R6]
        $stable(MODE_REG) && !run && DQ_OE_N)
        else $error("Input acted on in a low-power state");

    AST_SR_EXIT: assert property (SELF_REFRESH && CKE |-> INT_CLK_RUN ##1 run) // [R5]
        else $error("Self refresh exit not recognised");

    AST_CLK_STOP: assert property (!run && !CKE |-> !INT_CLK_RUN) // [R3]
        else $error("Internal clocks running while gated");

    AST_READ_STROBE: assert property (is_rd |=> !DQ_OE_N && !DATA_STROBE_OE_N &&
        LOWER_DATA_STROBE_OUT == STROBE_READ ##1 DQ_OE_N == !$past(is_rd)) // [R14]
        else $error("Read strobe not driven with data");

    COV_SELF_REF: cover property (run && !CKE && cmd == LPDCI_REF ##1 SELF_REFRESH ##[1:8] run);
    COV_ACT_PD: cover property (PD_ACTIVE ##1 run);
    COV_MASKED_WRITE: cover property (wr_pend_ff && LOWER_BYTE_MASK[0] && !UPPER_BYTE_MASK[1]);
    COV_READ_AP: cover property (is_rd && ADDR[AP_BIT]);

endmodule // lpdci_top

// *** lpdci_pkg.sv ***
// Purpose: Shared constants and types for the command and control input stage
// Assumes: One 250 MHz clock standing for the rising crossing of the clock pair
// Notes: Double-rate data is carried as a rise beat and a fall beat per cycle

package lpdci_pkg;

    // ************************************************************
    // Widths and sizes
    // ************************************************************
    localparam int DQ_W = 16;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int LANES = 2;
    localparam int BYTE_W = 8;
    localparam int BEATS = 2;
    localparam int HALF_IDX_W = 3;
    localparam int HALF_DEPTH = 8;
    localparam int AP_BIT = 10;
    localparam int COL_PAIR_BIT = 1;

    // ************************************************************
    // Clock and latency
    // ************************************************************
    localparam real CLK_PERIOD_NS = 4.0;
    localparam int RD_LAT_CYC = 1;
    localparam int WR_LAT_CYC = 1;

    // ************************************************************
    // Command codes {ras_n, cas_n, we_n} with die-select low
    // ************************************************************
    localparam logic [2:0] CODE_LMR = 3'h0;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_RD = 3'h5;
    localparam logic [2:0] CODE_BST = 3'h6;

    // ************************************************************
    // Mode register select, reset values and read strobe patterns
    // ************************************************************
    localparam logic [BA_W-1:0] MR_SEL_STD = 2'h0;
    localparam logic [BA_W-1:0] MR_SEL_EXT = 2'h2;
    localparam logic [ADDR_W-1:0] MODE_REG_RST = 13'h0000;
    localparam logic [ADDR_W-1:0] EXT_MODE_REG_RST = 13'h0000;
    localparam logic [1:0] STROBE_READ = 2'h1;
    localparam logic [1:0] STROBE_IDLE = 2'h0;

    typedef enum {LPDCI_NOP, LPDCI_LMR, LPDCI_REF, LPDCI_PRE, LPDCI_ACT,
                  LPDCI_WR, LPDCI_RD, LPDCI_BST} lpdci_cmd_t;

    typedef enum {LPDCI_RUN, LPDCI_PRE_PD, LPDCI_ACT_PD, LPDCI_SELF_REF} lpdci_pwr_t;

endpackage

// *** lpdci_ctrl_model.sv ***
// Purpose: Memory controller model driving the command and write-data inputs
// Assumes: Driven just after the rising edge of clk, one request per call
// Notes: Released data and mask lines toggle every cycle instead of holding

`timescale 1ns/1ps

module lpdci_ctrl_model
    import lpdci_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command and address
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr,
    // Write data, strobes and masks
    output logic [DQ_W-1:0] dq_rise,
    output logic [DQ_W-1:0] dq_fall,
    output logic [BEATS-1:0] lo_strobe,
    output logic [BEATS-1:0] up_strobe,
    output logic [BEATS-1:0] lo_mask,
    output logic [BEATS-1:0] up_mask
);
    // ************************************************************
    // Drive tasks
    // ************************************************************
    initial
    begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
        ba = 2'h0;
        addr = 13'h0000;
        {dq_rise, dq_fall} = 32'h0000_0000;
        {lo_strobe, up_strobe, lo_mask, up_mask} = 8'h00;
    end

    task automatic send(input logic cs_v, input logic [2:0] code, input logic [BA_W-1:0] ba_v,
                        input logic [ADDR_W-1:0] addr_v, input logic cke_v);
        @(posedge clk);
        cke <= cke_v;
        cs_n <= cs_v;
        {ras_n, cas_n, we_n} <= code;
        ba <= ba_v;
        addr <= addr_v;
        dq_rise <= ~dq_rise;
        dq_fall <= ~dq_fall;
        lo_mask <= ~lo_mask;
        up_mask <= ~up_mask;
        lo_strobe <= 2'h0;
        up_strobe <= 2'h0;
    endtask

    task automatic beats(input logic [DQ_W-1:0] r, input logic [DQ_W-1:0] f,
                         input logic [BEATS-1:0] lm, input logic [BEATS-1:0] um,
                         input logic [BEATS-1:0] ls, input logic [BEATS-1:0] us);
        @(posedge clk);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= 3'h7;
        dq_rise <= r;
        dq_fall <= f;
        lo_mask <= lm;
        up_mask <= um;
        lo_strobe <= ls;
        up_strobe <= us;
    endtask
endmodule // lpdci_ctrl_model

// *** lpdci_top_bench.sv ***
// Purpose: Self-checking bench for the command and control input stage
// Assumes: Latencies and codes as fixed in the package
// Notes: Every wait is a fixed count; a watchdog ends a hung run

`timescale 1ns/1ps

module lpdci_top_bench;
    import lpdci_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk;
    logic nrst_n;
    int fails;
    int n_tests;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg;
    logic [DQ_W-1:0] dq_ri, dq_fi, dq_ro, dq_fo;
    logic [BEATS-1:0] ls_i, us_i, lm, um, ls_o, us_o;
    logic dq_oe_n, dqs_oe_n, clk_run, buf_en, pd_pre, pd_act, self_ref;
    logic [NUM_BANKS-1:0] bank_open;

    lpdci_top u_lpdci_top (.CLK(clk), .NRST(nrst_n), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
        .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .DQ_RISE_IN(dq_ri),
        .DQ_FALL_IN(dq_fi), .LOWER_DATA_STROBE_IN(ls_i), .UPPER_DATA_STROBE_IN(us_i),
        .LOWER_BYTE_MASK(lm), .UPPER_BYTE_MASK(um), .DQ_RISE_OUT(dq_ro), .DQ_FALL_OUT(dq_fo),
        .DQ_OE_N(dq_oe_n), .LOWER_DATA_STROBE_OUT(ls_o), .UPPER_DATA_STROBE_OUT(us_o),
        .DATA_STROBE_OE_N(dqs_oe_n), .INT_CLK_RUN(clk_run), .INPUT_BUF_EN(buf_en),
        .PD_PRECHARGE(pd_pre), .PD_ACTIVE(pd_act), .SELF_REFRESH(self_ref),
        .BANK_OPEN(bank_open), .MODE_REG(mode_reg), .EXT_MODE_REG(ext_mode_reg));

    lpdci_ctrl_model u_lpdci_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_rise(dq_ri), .dq_fall(dq_fi),
        .lo_strobe(ls_i), .up_strobe(us_i), .lo_mask(lm), .up_mask(um));

    // ************************************************************
    // Clock, helpers and report
    // ************************************************************
    initial clk = 1'b0;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

    task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [2:0] code, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
        u_lpdci_ctrl_model.send(1'b0, code, b, a, 1'b1);
    endtask

    task automatic nop(input int n);
        repeat (n) u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b1);
    endtask

    task automatic settle();
        nop(1);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        @(negedge clk);
        check(bank_open, 4'h0);
        check(mode_reg, MODE_REG_RST);
        check(ext_mode_reg, EXT_MODE_REG_RST);
        check({dq_oe_n, dqs_oe_n, buf_en, clk_run}, 4'hf);
        check({ls_o, us_o}, 4'h0);
    endtask

    task automatic t_mode();
        cmd(CODE_LMR, MR_SEL_STD, 13'h0032);
        cmd(CODE_LMR, MR_SEL_EXT, 13'h0021);
        cmd(CODE_LMR, 2'h1, 13'h1fff);
        cmd(CODE_LMR, 2'h3, 13'h1fff);
        u_lpdci_ctrl_model.send(1'b1, CODE_LMR, MR_SEL_STD, 13'h0fff, 1'b1);
        settle();
        check(mode_reg, 13'h0032);
        check(ext_mode_reg, 13'h0021);
    endtask

    task automatic t_banks();
        logic [NUM_BANKS-1:0] exp;
        exp = 4'h0;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            cmd(CODE_ACT, BA_W'(b), 13'h0000);
            settle();
            exp[b] = 1'b1;
            check(bank_open, exp);
        end
        cmd(CODE_PRE, 2'h2, 13'h0000);
        settle();
        check(bank_open, 4'hb);
        cmd(CODE_PRE, 2'h0, 13'h0400);
        settle();
        check(bank_open, 4'h0);
    endtask

    task automatic t_write_read();
        cmd(CODE_ACT, 2'h1, 13'h0000);
        cmd(CODE_WR, 2'h1, 13'h0002);
        u_lpdci_ctrl_model.beats(16'h1234, 16'habcd, 2'h1, 2'h2, 2'h3, 2'h3);
        cmd(CODE_WR, 2'h1, 13'h0000);
        u_lpdci_ctrl_model.beats(16'h5566, 16'h7788, 2'h0, 2'h0, 2'h3, 2'h1);
        cmd(CODE_RD, 2'h1, 13'h0002);
        settle();
        check(dq_ro, 16'h1200);
        check(dq_fo, 16'h00cd);
        check({dq_oe_n, dqs_oe_n}, 2'h0);
        check({ls_o, us_o}, {STROBE_READ, STROBE_READ});
        @(negedge clk);
        check({dq_oe_n, dqs_oe_n}, 2'h3);
        check({ls_o, us_o}, {STROBE_IDLE, STROBE_IDLE});
        cmd(CODE_RD, 2'h1, 13'h0400);
        settle();
        check(dq_ro, 16'h5566);
        check(dq_fo, 16'h0088);
        check(bank_open, 4'h2);
        nop(2);
        @(negedge clk);
        check(bank_open, 4'h0);
        cmd(CODE_ACT, 2'h2, 13'h0000);
        cmd(CODE_WR, 2'h2, 13'h0400);
        cmd(CODE_BST, 2'h0, 13'h0000);
        cmd(CODE_REF, 2'h0, 13'h0000);
        settle();
        check(bank_open, 4'h0);
        check(mode_reg, 13'h0032);
    endtask

    task automatic t_power();
        u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b0);
        u_lpdci_ctrl_model.send(1'b0, CODE_ACT, 2'h0, 13'h0000, 1'b0);
        @(negedge clk);
        check({pd_pre, pd_act, self_ref, buf_en, clk_run}, 5'h10);
        u_lpdci_ctrl_model.send(1'b0, CODE_ACT, 2'h0, 13'h0000, 1'b1);
        #1;
        check({clk_run, pd_pre}, 2'h3);
        settle();
        check({pd_pre, buf_en}, 2'h1);
        check(bank_open, 4'h0);
        cmd(CODE_ACT, 2'h3, 13'h0000);
        u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b0);
        u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b0);
        @(negedge clk);
        check({pd_pre, pd_act, self_ref}, 3'h2);
        nop(1);
        settle();
        check({pd_act, bank_open}, 5'h08);
        cmd(CODE_PRE, 2'h0, 13'h0400);
        u_lpdci_ctrl_model.send(1'b0, CODE_REF, 2'h0, 13'h0000, 1'b0);
        u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b0);
        @(negedge clk);
        check({pd_pre, pd_act, self_ref, clk_run}, 4'h2);
        u_lpdci_ctrl_model.send(1'b1, 3'h7, 2'h0, 13'h0000, 1'b1);
        #1;
        check({clk_run, self_ref}, 2'h3);
        settle();
        check({self_ref, buf_en}, 2'h1);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial
    begin
        fails = 0;
        n_tests = 0;
        nrst_n = 1'b0;
        repeat (16) @(posedge clk);
        nrst_n <= 1'b1;
        t_reset();
        t_mode();
        t_banks();
        t_write_read();
        t_power();
        nop(2);
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule // lpdci_top_bench
